/* File: verilog/iwsg_pkg.sv */
package iwsg_pkg;

	// width of the cpu i/o address
	localparam int ADDR_W = 8;

	// extra cpu wait states per i/o cycle, per peripheral grade
	localparam logic [3:0] SLOW_WR_WAITS = 4'h2;
	localparam logic [3:0] SLOW_RD_WAITS = 4'h2;
	localparam logic [3:0] FAST_WR_WAITS = 4'h1;
	localparam logic [3:0] FAST_RD_WAITS = 4'h1;

	// system clock cycles per cpu clock (t-state)
	localparam logic [3:0] CYC_PER_TSTATE = 4'h1;

	// default decode: peripheral answers at 0x80..0x83
	localparam logic [ADDR_W-1:0] PERIPH_BASE = 8'h80;
	localparam logic [ADDR_W-1:0] PERIPH_MASK = 8'hFC;

	// inactive level of every active-low strobe
	localparam logic STROBE_OFF = 1'b1;
	localparam logic STROBE_ON  = 1'b0;

	// cpu side pins, all active low except the address
	typedef struct packed {
		logic              io_request_n;
		logic              rd_n;
		logic              wr_n;
		logic [ADDR_W-1:0] addr;
	} iwsg_cpu_bus_type;

	// peripheral side strobes, all active low
	typedef struct packed {
		logic ce_n;
		logic rd_n;
		logic wr_n;
	} iwsg_periph_bus_type;

	// reset value of the peripheral strobes
	localparam iwsg_periph_bus_type PERIPH_IDLE = '{
		ce_n: 1'b1,
		rd_n: 1'b1,
		wr_n: 1'b1
	};

endpackage

/* File: verilog/iwsg_wait_counter.sv */
`timescale 1ns/1ps
module iwsg_wait_counter #(
	parameter int CNT_W = 8
) (
	input  wire logic             clk_i,
	input  wire logic             rst_n_i,
	input  wire logic             load_i,
	input  wire logic [CNT_W-1:0] load_val_i,
	output logic                  busy_o
);
	import iwsg_pkg::*;

	logic [CNT_W-1:0] cnt_ff;
	logic [CNT_W-1:0] nxt_cnt;

	// counts system clock pulses down to zero; load wins over counting
	always_comb begin
		nxt_cnt = cnt_ff;
		if (load_i) begin
			nxt_cnt = load_val_i;
		end else if (cnt_ff != '0) begin
			nxt_cnt = cnt_ff - CNT_W'(1);
		end
	end

	// cleared on reset so no stale wait survives
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			cnt_ff <= '0;
		end else begin
			cnt_ff <= nxt_cnt;
		end
	end

	assign busy_o = (cnt_ff != '0);

endmodule

/* File: verilog/iwsg_top.sv */
`timescale 1ns/1ps
module iwsg_top #(
	parameter bit SLOW_GRADE   = 1'b1,
	parameter bit SAME_WAITS   = 1'b1,
	parameter bit STALL_ALL_IO = 1'b0,
	parameter int CNT_W        = 8
) (
	input  wire logic                        clk_i,
	input  wire logic                        rst_n_i,
	input  wire iwsg_pkg::iwsg_cpu_bus_type  cpu_i,
	output iwsg_pkg::iwsg_periph_bus_type    periph_o,
	output logic                             cpu_wait_n_o
);
	import iwsg_pkg::*;

	// the counter must hold the largest wait figure times the t-state length
	generate
		if (CNT_W < 8 || CNT_W > 16) begin : g_bad_cnt_w
			$error("iwsg_top: CNT_W must lie between 8 and 16");
		end
		// a zero t-state length would release the cpu with no counted wait at all
		if (CYC_PER_TSTATE == 4'h0) begin : g_bad_tstate
			$error("iwsg_top: CYC_PER_TSTATE must not be zero");
		end
		// every grade needs at least one counted wait on each cycle kind
		if (SLOW_RD_WAITS == 4'h0 || SLOW_WR_WAITS == 4'h0 ||
			FAST_RD_WAITS == 4'h0 || FAST_WR_WAITS == 4'h0) begin : g_bad_waits
			$error("iwsg_top: every wait figure must be at least one");
		end
		// base bits outside the mask would be silently dropped by the decode
		if ((PERIPH_BASE & ~PERIPH_MASK) != '0) begin : g_bad_base
			$error("iwsg_top: PERIPH_BASE has bits outside PERIPH_MASK");
		end
	endgenerate

	// sequencer states, one peripheral cycle from request to release
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_SETUP,
		ST_STROBE,
		ST_HOLD
	} iwsg_state_type;

	// decoding shared by the chip enable and the wait selection
	// kept in one place so both agree about the window unless STALL_ALL_IO stalls every i/o cycle
	function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
		addr_hit = ((a & PERIPH_MASK) == (PERIPH_BASE & PERIPH_MASK));
	endfunction

	// wait count for one cycle kind, grade and sharing option applied
	// the shared count takes the larger figure so neither kind falls short
	function automatic logic [3:0] waits_for(input logic is_wr);
		logic [3:0] rd_w;
		logic [3:0] wr_w;
		rd_w = SLOW_GRADE ? SLOW_RD_WAITS : FAST_RD_WAITS;
		wr_w = SLOW_GRADE ? SLOW_WR_WAITS : FAST_WR_WAITS;
		if (SAME_WAITS) begin
			waits_for = (rd_w > wr_w) ? rd_w : wr_w;
		end else begin
			waits_for = is_wr ? wr_w : rd_w;
		end
	endfunction

	// two-stage synchroniser on the cpu pins; stage one feeds stage two only
	iwsg_cpu_bus_type sync1_ff;
	iwsg_cpu_bus_type sync2_ff;
	iwsg_cpu_bus_type nxt_sync1;
	iwsg_cpu_bus_type nxt_sync2;

	always_comb begin
		nxt_sync1 = cpu_i;
		nxt_sync2 = sync1_ff;
	end

	// idle pin levels after reset so no false cycle is seen
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			sync1_ff <= '{io_request_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1,
				addr: '0};
			sync2_ff <= '{io_request_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1,
				addr: '0};
		end else begin
			sync1_ff <= nxt_sync1;
			sync2_ff <= nxt_sync2;
		end
	end

	// qualified view of the synchronised cpu cycle
	logic io_active;
	logic io_strobe;
	logic io_selected;
	logic cpu_released;

	// the address is synced bit by bit, which is only safe because the
	// cpu holds it steady for the whole request
	assign io_active    = (sync2_ff.io_request_n == STROBE_ON);
	assign io_strobe    = (sync2_ff.rd_n == STROBE_ON) ||
		(sync2_ff.wr_n == STROBE_ON);
	assign io_selected  = STALL_ALL_IO || addr_hit(sync2_ff.addr);
	assign cpu_released = (sync2_ff.rd_n == STROBE_OFF) &&
		(sync2_ff.wr_n == STROBE_OFF);

	// wait counter, loaded once per cycle when the strobe goes out
	logic             cnt_load;
	logic [CNT_W-1:0] cnt_val;
	logic             cnt_busy;

	iwsg_wait_counter #(
		.CNT_W      (CNT_W)
	) u_wait_cnt (
		.clk_i      (clk_i),
		.rst_n_i    (rst_n_i),
		.load_i     (cnt_load),
		.load_val_i (cnt_val),
		.busy_o     (cnt_busy)
	);

	// cycle state and the registered outputs
	iwsg_state_type      state_ff;
	iwsg_state_type      nxt_state;
	logic                is_wr_ff;
	logic                nxt_is_wr;
	iwsg_periph_bus_type periph_ff;
	iwsg_periph_bus_type nxt_periph;
	logic                wait_n_ff;
	logic                nxt_wait_n;

	// one peripheral cycle, counted from the edge the synced request shows:
	//   edge 0: wait goes low, chip enable follows the decode
	//   edge 1: the strobe falls, a whole clock after the address settled
	//   edge 1 on: the counter runs off the wait figure
	//   edge n+2: wait released, the cpu may finish its own t-states
	//   later: the strobe rises three edges after the cpu lifts its own, two of them in the sync flops
	// the two sync flops add two clocks before edge 0; that is the price
	// of sampling pins from a cpu that does not share this clock
	// a strobe is never cut short by the counter, only by the cpu, so
	// the width can only grow beyond the figure, never shrink below it
	// cycle sequencer; strobes only change on the registered clock edge
	always_comb begin
		nxt_state  = state_ff;
		nxt_is_wr  = is_wr_ff;
		nxt_periph = periph_ff;
		nxt_wait_n = wait_n_ff;
		cnt_load   = 1'b0;
		cnt_val    = '0;
		// chip enable follows decode and request, independent of strobes
		nxt_periph.ce_n = !(io_active && addr_hit(sync2_ff.addr));
		case (state_ff)
			ST_IDLE: begin
				nxt_periph.rd_n = STROBE_OFF;
				nxt_periph.wr_n = STROBE_OFF;
				// a strobe without the i/o request is a memory cycle: ignored
				if (io_active && io_strobe && io_selected) begin
					// stall at once, before the strobe is even released
					nxt_wait_n = STROBE_ON;
					nxt_is_wr  = (sync2_ff.wr_n == STROBE_ON);
					nxt_state  = ST_SETUP;
				end
			end
			ST_SETUP: begin
				// one more edge of address settling before the strobe falls
				nxt_periph.rd_n = is_wr_ff ? STROBE_OFF : STROBE_ON;
				nxt_periph.wr_n = is_wr_ff ? STROBE_ON : STROBE_OFF;
				cnt_load  = 1'b1;
				cnt_val   = CNT_W'(waits_for(is_wr_ff)) *
					CNT_W'(CYC_PER_TSTATE);
				nxt_state = ST_STROBE;
			end
			ST_STROBE: begin
				// strobe stays low for the whole wait count
				// the cpu cannot end its cycle here, it is still held in
				// wait; the hold state picks up its release afterwards
				if (!cnt_busy) begin
					nxt_wait_n = STROBE_OFF;
					nxt_state  = ST_HOLD;
				end
			end
			ST_HOLD: begin
				// strobe ends only when the cpu ends its own cycle
				if (cpu_released) begin
					nxt_periph.rd_n = STROBE_OFF;
					nxt_periph.wr_n = STROBE_OFF;
					nxt_state       = ST_IDLE;
				end
			end
			default: begin
				nxt_state = ST_IDLE;
			end
		endcase
	end

	// reset releases wait and both strobes
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			state_ff  <= ST_IDLE;
			is_wr_ff  <= 1'b0;
			periph_ff <= PERIPH_IDLE;
			wait_n_ff <= STROBE_OFF;
		end else begin
			state_ff  <= nxt_state;
			is_wr_ff  <= nxt_is_wr;
			periph_ff <= nxt_periph;
			wait_n_ff <= nxt_wait_n;
		end
	end

	// outputs straight from flops
	// nothing combinational reaches a pin, so no glitch can strobe the part
	assign periph_o     = periph_ff;
	assign cpu_wait_n_o = wait_n_ff;

endmodule

/* File: testbench/iwsg_checker.sv */
`timescale 1ns/1ps
module iwsg_checker
	import iwsg_pkg::*;
(
	input wire logic                  clk_i,
	input wire logic                  rst_n_i,
	input wire iwsg_cpu_bus_type      cpu_i,
	input wire iwsg_periph_bus_type   periph_o,
	input wire logic                  cpu_wait_n_o
);
	// a synchronous reset must leave everything idle one edge later
	a_reset_idle: assert property (@(posedge clk_i) !rst_n_i |=>
		periph_o == PERIPH_IDLE && cpu_wait_n_o)
		else $error("outputs not idle after reset");
	// a strobe may only fall while the cpu is already held in wait
	a_rd_strobe_late: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		$fell(periph_o.rd_n) |-> !$past(cpu_wait_n_o))
		else $error("read strobe not held back behind wait");
	a_wr_strobe_late: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		$fell(periph_o.wr_n) |-> !$past(cpu_wait_n_o))
		else $error("write strobe not held back behind wait");
	// setup, two counted waits, one closing cycle
	a_wait_width: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		$fell(cpu_wait_n_o) |-> !cpu_wait_n_o[*4] ##1 cpu_wait_n_o)
		else $error("wait low span wrong");
	// pins pass two sync flops and one sequencer edge before a reply
	a_ce_decoded: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		$fell(periph_o.ce_n) |-> !$past(cpu_i.io_request_n, 3) &&
		(($past(cpu_i.addr, 3) & PERIPH_MASK) == PERIPH_BASE))
		else $error("chip enable without decoded request");
	a_strobe_in_ce: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		(!periph_o.rd_n || !periph_o.wr_n) |-> !periph_o.ce_n)
		else $error("strobe outside chip enable");
	a_rd_release: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		$rose(cpu_i.rd_n) |-> ##[2:4] periph_o.rd_n)
		else $error("read strobe not released");
	a_wait_cause: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		$fell(cpu_wait_n_o) |-> !$past(cpu_i.io_request_n, 3) &&
		(($past(cpu_i.addr, 3) & PERIPH_MASK) == PERIPH_BASE))
		else $error("wait without decoded request");
endmodule

/* File: testbench/iwsg_periph_model.sv */
`timescale 1ns/1ps
module iwsg_periph_model (
	input  wire logic                          clk_i,
	input  wire iwsg_pkg::iwsg_periph_bus_type periph_i,
	output logic [7:0]                         low_cnt_o,
	output logic                               last_wr_o
);
	import iwsg_pkg::*;
	logic [7:0] run_ff  = 8'h00;
	logic       kind_ff = 1'b0;
	// peripheral measures each strobe pulse and notes which strobe it was,
	// so a lost strobe cannot hide behind the width of the one before
	always_ff @(posedge clk_i) begin
		if (!periph_i.ce_n &&
			(!periph_i.rd_n || !periph_i.wr_n)) begin
			run_ff  <= run_ff + 8'h01;
			kind_ff <= !periph_i.wr_n;
		end else begin
			if (run_ff != 8'h00) begin
				low_cnt_o <= run_ff;
				last_wr_o <= kind_ff;
			end
			run_ff <= 8'h00;
		end
	end
endmodule

/* File: testbench/io_wait_strobe_delay_glue_tb.sv */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin errors++; \
	$display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module io_wait_strobe_delay_glue_tb;
	import iwsg_pkg::*;
	logic                clk_i = 1'b0;
	logic                rst_n_i = 1'b0;
	iwsg_cpu_bus_type    cpu = '{1'b1, 1'b1, 1'b1, 8'h00};
	iwsg_periph_bus_type per;
	logic                wt_n;
	logic [7:0]          pw;
	logic                lw;
	int                  errors = 0;
	int                  n_checks = 0;
	initial forever #2.5 clk_i = ~clk_i;
	iwsg_top uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .cpu_i(cpu),
		.periph_o(per), .cpu_wait_n_o(wt_n));
	iwsg_periph_model pm (.clk_i(clk_i), .periph_i(per), .low_cnt_o(pw),
		.last_wr_o(lw));
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// one cpu i/o cycle; the cpu drops its strobe once wait is released
	task automatic io(input bit rd, input logic [7:0] a, input logic [3:0] ew);
		logic [3:0] w;
		w = 4'h0;
		cpu.addr = a;
		cpu.io_request_n = 1'b0;
		if (rd) cpu.rd_n = 1'b0;
		else cpu.wr_n = 1'b0;
		for (int i = 0; i < 20; i++) begin
			@(posedge clk_i); #1;
			if (wt_n === 1'b0) w++;
			else if (w != 4'h0) break;
		end
		cpu.rd_n = 1'b1;
		cpu.wr_n = 1'b1;
		repeat (6) @(posedge clk_i);
		#1 cpu.io_request_n = 1'b1;
		repeat (5) @(posedge clk_i);
		#1 `CHK("wait cycles", ew, w)
		`CHK("ce idle", 1'b1, per.ce_n)
	endtask
	// both directions against the slow grade, same count each way
	task automatic t_hits;
		io(1'b1, 8'h80, 4'h2 + SLOW_RD_WAITS);
		`CHK("rd width ok", 1'b1, pw >= 8'h4)
		`CHK("rd strobe kind", 1'b0, lw)
		io(1'b0, 8'h83, 4'h2 + SLOW_WR_WAITS);
		`CHK("wr width ok", 1'b1, pw >= 8'h4)
		`CHK("wr strobe kind", 1'b1, lw)
		$display("test hits done");
	endtask
	// just outside the decode: no wait, no strobe
	task automatic t_miss;
		io(1'b1, 8'h84, 4'h0);
		`CHK("miss no rd strobe", 1'b1, lw)
		io(1'b0, 8'h7F, 4'h0);
		$display("test miss done");
	endtask
	// reset in mid-cycle clears wait and strobes
	task automatic t_reset_mid;
		cpu = '{1'b0, 1'b1, 1'b0, 8'h81};
		repeat (5) @(posedge clk_i);
		#1 rst_n_i = 1'b0;
		repeat (2) @(posedge clk_i);
		#1 `CHK("wait idle", 1'b1, wt_n)
		`CHK("strobes idle", PERIPH_IDLE, per)
		cpu = '{1'b1, 1'b1, 1'b1, 8'h81};
		repeat (3) @(posedge clk_i);
		#1 rst_n_i = 1'b1;
		io(1'b0, 8'h82, 4'h2 + SLOW_WR_WAITS);
		`CHK("wr after reset", 1'b1, pw >= 8'h4)
		`CHK("wr kind after reset", 1'b1, lw)
		$display("test reset done");
	endtask
	initial begin
		repeat (8) @(posedge clk_i);
		#1 `CHK("reset wait", 1'b1, wt_n)
		rst_n_i = 1'b1;
		repeat (3) @(posedge clk_i);
		#1 t_hits();
		t_miss();
		t_reset_mid();
		tally_and_finish();
	end
	initial begin
		#20000 errors++;
		tally_and_finish();
	end
endmodule
bind iwsg_top iwsg_checker chk (.clk_i(clk_i), .rst_n_i(rst_n_i),
	.cpu_i(cpu_i), .periph_o(periph_o), .cpu_wait_n_o(cpu_wait_n_o));
